// File: rtl/sla_alarm_unit.sv
// Serial link alarm unit: sticky alarm flags, masks, summary alarm and offset register.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module sla_alarm_unit
    import sla_pkg::*;
#(
    parameter logic [15:0] OFFSET_FUSE = SLA_OFS_RST
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic [11:0] ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    input  wire logic [7:0]  LANE_FIFO_ERR,
    input  wire logic        PLL_UNLOCKED,
    input  wire logic        LINK_DATA_PHASE,
    input  wire logic        LINK_RESTART,
    input  wire logic        SYSREF_REALIGN,
    input  wire logic        DIVIDER_MISMATCH,
    input  wire logic        CAL_DONE,
    output logic [15:0]      RDATA,
    output logic             ALARM,
    output logic             CALIBRATION_STATUS_PIN,
    output logic             SERIAL_LINK_ENABLE,
    output logic [11:0]      CORE0_OFFSET_ADJUST
);

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    sla_bus_t   bus;
    sla_evt_t   evt;
    sla_state_t st;
    sla_state_t next_st;
    logic [7:0] lane_set;
    logic [7:0] stat_set;
    logic [7:0] wclr;

    // Pack the ports into their carriers.
    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign evt = '{lane_fifo_err: LANE_FIFO_ERR, pll_unlocked: PLL_UNLOCKED,
                   link_data_phase: LINK_DATA_PHASE, link_restart: LINK_RESTART,
                   sysref_realign: SYSREF_REALIGN, divider_mismatch: DIVIDER_MISMATCH};

    // ------------------------------------------------------------------
    // Per-lane alarm sources
    // ------------------------------------------------------------------
    // One set term per lane; a lane counts only once the link is running.
    genvar gi;
    generate
        for (gi = 0; gi < SLA_LANES; gi++) begin : g_lane
            assign lane_set[gi] = evt.lane_fifo_err[gi] & st.ctrl[SLA_CTRL_LINK_EN];
        end
    endgenerate

    // Status set terms. In 64b/66b mode link start-up is the rising edge of the enable.
    always_comb begin
        stat_set = 8'h00;
        stat_set[SLA_BIT_FIFO]    = |lane_set;
        stat_set[SLA_BIT_PLL]     = evt.pll_unlocked;
        if (st.ctrl[SLA_CTRL_MODE66]) begin
            stat_set[SLA_BIT_LINK] = (st.ctrl[SLA_CTRL_LINK_EN] & ~st.link_en_q)
                                     | evt.link_restart;
        end else begin
            stat_set[SLA_BIT_LINK] = st.ctrl[SLA_CTRL_LINK_EN] & ~evt.link_data_phase;
        end
        stat_set[SLA_BIT_REALIGN] = evt.sysref_realign;
        stat_set[SLA_BIT_CLK]     = evt.divider_mismatch;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Set always beats a clear in the same cycle so no event is lost.
    always_comb begin
        next_st = st;
        wclr    = 8'h00;
        next_st.link_en_q = st.ctrl[SLA_CTRL_LINK_EN];
        if (bus.wr && bus.addr == SLA_OFF_STATUS) begin
            wclr = bus.wdata[7:0] & SLA_ALARM_BITS;
        end
        // Write one clears, zero leaves the flag as it was.
        next_st.status = ((st.status & ~wclr) | stat_set) & SLA_STATUS_RST;
        // Clearing the FIFO summary bit wipes every lane bit not set again in this cycle.
        if (wclr[SLA_BIT_FIFO]) begin
            next_st.lane = lane_set;
        end else if (bus.wr && bus.addr == SLA_OFF_LANE) begin
            next_st.lane = (st.lane & ~bus.wdata[7:0]) | lane_set;
        end else begin
            next_st.lane = st.lane | lane_set;
        end
        // Register writes; reserved mask bits are stored as written.
        if (bus.wr && bus.addr == SLA_OFF_MASK) begin
            next_st.mask = bus.wdata[7:0];
        end else if (bus.wr && bus.addr == SLA_OFF_OFFSET) begin
            next_st.offset = bus.wdata & SLA_OFS_FIELD;
        end else if (bus.wr && bus.addr == SLA_OFF_CTRL) begin
            next_st.ctrl = bus.wdata[7:0];
        end
        // Summary alarm from unmasked flags of this cycle.
        next_st.alarm   = |(st.status & ~st.mask & SLA_ALARM_BITS);
        next_st.cal_pin = st.ctrl[SLA_CTRL_STAT_SEL] ?
                          next_st.alarm : CAL_DONE;
        // Read data is registered, so it stands only in the cycle after the strobe.
        next_st.rdata = 16'h0000;
        if (bus.rd) begin
            if (bus.addr == SLA_OFF_SUMMARY) begin
                next_st.rdata = {15'h0000, st.alarm};
            end else if (bus.addr == SLA_OFF_STATUS) begin
                next_st.rdata = {8'h00, st.status};
            end else if (bus.addr == SLA_OFF_MASK) begin
                next_st.rdata = {8'h00, st.mask};
            end else if (bus.addr == SLA_OFF_LANE) begin
                next_st.rdata = {8'h00, st.lane};
            end else if (bus.addr == SLA_OFF_OFFSET) begin
                next_st.rdata = st.offset;
            end else if (bus.addr == SLA_OFF_CTRL) begin
                next_st.rdata = {8'h00, st.ctrl};
            end else begin
                next_st.rdata = 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // The offset default is a constant parameter standing in for fuse data.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st.status    <= SLA_STATUS_RST;
            st.mask      <= SLA_MASK_RST;
            st.lane      <= SLA_LANE_RST;
            st.offset    <= OFFSET_FUSE & SLA_OFS_FIELD;
            st.ctrl      <= SLA_CTRL_RST;
            st.rdata     <= 16'h0000;
            st.alarm     <= 1'b0;
            st.cal_pin   <= 1'b0;
            st.link_en_q <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from state flip-flops.
    assign RDATA                  = st.rdata;
    assign ALARM                  = st.alarm;
    assign CALIBRATION_STATUS_PIN = st.cal_pin;
    assign SERIAL_LINK_ENABLE     = st.ctrl[SLA_CTRL_LINK_EN];
    assign CORE0_OFFSET_ADJUST    = st.offset[11:0];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_fifo_set;
        @(posedge CLK) disable iff (!RESET_N)
        (|lane_set) |=> st.status[SLA_BIT_FIFO] && (st.lane != 8'h00);
    endproperty
    a_fifo_set: assert property (p_fifo_set) else $error("FIFO alarm not set.");

    property p_pll_set;
        @(posedge CLK) disable iff (!RESET_N)
        PLL_UNLOCKED |=> st.status[SLA_BIT_PLL];
    endproperty
    a_pll_set: assert property (p_pll_set) else $error("PLL alarm not set.");

    property p_link8;
        @(posedge CLK) disable iff (!RESET_N)
        (!st.ctrl[SLA_CTRL_MODE66] && st.ctrl[SLA_CTRL_LINK_EN] && !LINK_DATA_PHASE)
        |=> st.status[SLA_BIT_LINK];
    endproperty
    a_link8: assert property (p_link8) else $error("Link alarm missed in 8b10b.");

    property p_link66;
        @(posedge CLK) disable iff (!RESET_N)
        (st.ctrl[SLA_CTRL_MODE66] && LINK_RESTART) |=> st.status[SLA_BIT_LINK];
    endproperty
    a_link66: assert property (p_link66) else $error("Link alarm missed in 64b66b.");

    property p_realign;
        @(posedge CLK) disable iff (!RESET_N)
        SYSREF_REALIGN |=> st.status[SLA_BIT_REALIGN];
    endproperty
    a_realign: assert property (p_realign) else $error("Realign alarm not set.");

    property p_clk;
        @(posedge CLK) disable iff (!RESET_N)
        DIVIDER_MISMATCH |=> st.status[SLA_BIT_CLK];
    endproperty
    a_clk: assert property (p_clk) else $error("Clock alarm not set.");

    property p_sticky;
        @(posedge CLK) disable iff (!RESET_N)
        (st.status[SLA_BIT_CLK] && !(WR && ADDR == SLA_OFF_STATUS))
        |=> st.status[SLA_BIT_CLK];
    endproperty
    a_sticky: assert property (p_sticky) else $error("Flag dropped without clear.");

    property p_lane_wipe;
        @(posedge CLK) disable iff (!RESET_N)
        (WR && ADDR == SLA_OFF_STATUS && WDATA[SLA_BIT_FIFO] && lane_set == 8'h00)
        |=> st.lane == 8'h00;
    endproperty
    a_lane_wipe: assert property (p_lane_wipe) else $error("Lane bits not wiped.");

    property p_summary;
        @(posedge CLK) disable iff (!RESET_N)
        1'b1 |=> ALARM == |($past(st.status) & ~$past(st.mask) & SLA_ALARM_BITS);
    endproperty
    a_summary: assert property (p_summary) else $error("Summary alarm wrong.");

    property p_ofs_res;
        @(posedge CLK) disable iff (!RESET_N)
        (WR && ADDR == SLA_OFF_OFFSET) |=> st.offset[15:12] == 4'h0 ##1 st.offset[15:12] == 4'h0;
    endproperty
    a_ofs_res: assert property (p_ofs_res) else $error("Offset reserved bits set.");

    // A rising link enable in 64b/66b mode counts as a link start-up.
    property p_link_start;
        @(posedge CLK) disable iff (!RESET_N)
        (st.ctrl[SLA_CTRL_MODE66] && st.ctrl[SLA_CTRL_LINK_EN] && !st.link_en_q)
        |=> st.status[SLA_BIT_LINK];
    endproperty
    a_link_start: assert property (p_link_start) else $error("Start-up alarm missed.");

    // Lane errors are ignored while the link enable is low.
    property p_lane_idle;
        @(posedge CLK) disable iff (!RESET_N)
        !st.ctrl[SLA_CTRL_LINK_EN] |-> lane_set == 8'h00;
    endproperty
    a_lane_idle: assert property (p_lane_idle) else $error("Lane counted while idle.");

    // Every erroring lane shows in its own bit one cycle later.
    property p_lane_bits;
        @(posedge CLK) disable iff (!RESET_N)
        (lane_set != 8'h00) |=> (st.lane & $past(lane_set)) == $past(lane_set);
    endproperty
    a_lane_bits: assert property (p_lane_bits) else $error("Lane bit not set.");

    // A lane write clears the written bits unless that lane is still in error.
    property p_lane_clear;
        @(posedge CLK) disable iff (!RESET_N)
        (WR && ADDR == SLA_OFF_LANE)
        |=> (st.lane & $past(WDATA[7:0]) & ~$past(lane_set)) == 8'h00;
    endproperty
    a_lane_clear: assert property (p_lane_clear) else $error("Lane bit not cleared.");

    // A zero written to a status bit leaves that flag as it was.
    property p_zero_keep;
        @(posedge CLK) disable iff (!RESET_N)
        (WR && ADDR == SLA_OFF_STATUS)
        |=> ($past(st.status) & ~$past(WDATA[7:0]) & ~st.status) == 8'h00;
    endproperty
    a_zero_keep: assert property (p_zero_keep) else $error("Zero write lost flag.");

    // Mask writes store the whole byte, reserved bits included.
    property p_mask_store;
        @(posedge CLK) disable iff (!RESET_N)
        (WR && ADDR == SLA_OFF_MASK) |=> st.mask == $past(WDATA[7:0]);
    endproperty
    a_mask_store: assert property (p_mask_store) else $error("Mask not stored.");

    // The pin carries the summary flag when selected, else the calibration status.
    property p_pin_route;
        @(posedge CLK) disable iff (!RESET_N)
        1'b1 |=> CALIBRATION_STATUS_PIN ==
                 ($past(st.ctrl[SLA_CTRL_STAT_SEL]) ? ALARM : $past(CAL_DONE));
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("Status pin wrong.");

    // ------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------
    c_fifo_clear: cover property (@(posedge CLK) disable iff (!RESET_N)
        WR && ADDR == SLA_OFF_STATUS && WDATA[SLA_BIT_FIFO] ##1 st.lane == 8'h00);
    c_alarm_rise: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(ALARM));
    c_pin_alarm: cover property (@(posedge CLK) disable iff (!RESET_N)
        st.ctrl[SLA_CTRL_STAT_SEL] && CALIBRATION_STATUS_PIN);
    c_read_mask: cover property (@(posedge CLK) disable iff (!RESET_N)
        RD && ADDR == SLA_OFF_MASK);
    c_link_start: cover property (@(posedge CLK) disable iff (!RESET_N)
        st.ctrl[SLA_CTRL_MODE66] && st.ctrl[SLA_CTRL_LINK_EN] && !st.link_en_q);

endmodule

// File: pkg/sla_pkg.sv
// Package for the serial link alarm unit: register map, field positions, reset values and types.
package sla_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] SLA_OFF_SUMMARY   = 12'h2C0;
    localparam logic [11:0] SLA_OFF_STATUS    = 12'h2C1;
    localparam logic [11:0] SLA_OFF_MASK      = 12'h2C2;
    localparam logic [11:0] SLA_OFF_LANE      = 12'h2C4;
    localparam logic [11:0] SLA_OFF_OFFSET    = 12'h330;
    localparam logic [11:0] SLA_OFF_CTRL      = 12'h2C8;

    // ------------------------------------------------------------------
    // Alarm and control bit positions
    // ------------------------------------------------------------------
    localparam int SLA_BIT_FIFO    = 5;
    localparam int SLA_BIT_PLL     = 4;
    localparam int SLA_BIT_LINK    = 3;
    localparam int SLA_BIT_REALIGN = 2;
    localparam int SLA_BIT_CLK     = 0;
    localparam int SLA_CTRL_LINK_EN  = 0;
    localparam int SLA_CTRL_MODE66   = 1;
    localparam int SLA_CTRL_STAT_SEL = 2;

    // ------------------------------------------------------------------
    // Reset values and field masks
    // ------------------------------------------------------------------
    localparam logic [7:0]  SLA_STATUS_RST = 8'h3F;
    localparam logic [7:0]  SLA_MASK_RST   = 8'h3F;
    localparam logic [7:0]  SLA_LANE_RST   = 8'hFF;
    localparam logic [7:0]  SLA_ALARM_BITS = 8'h3D;
    localparam logic [15:0] SLA_OFS_FIELD  = 16'h0FFF;
    localparam logic [15:0] SLA_OFS_RST    = 16'h0000;
    localparam logic [7:0]  SLA_CTRL_RST   = 8'h00;
    localparam int          SLA_LANES      = 8;

    // Register bus request.
    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } sla_bus_t;

    // Alarm sources from the link and clocking.
    typedef struct packed {
        logic [7:0] lane_fifo_err;
        logic       pll_unlocked;
        logic       link_data_phase;
        logic       link_restart;
        logic       sysref_realign;
        logic       divider_mismatch;
    } sla_evt_t;

    // Whole state of the unit.
    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  mask;
        logic [7:0]  lane;
        logic [15:0] offset;
        logic [7:0]  ctrl;
        logic [15:0] rdata;
        logic        alarm;
        logic        cal_pin;
        logic        link_en_q;
    } sla_state_t;

endpackage

// File: testbench/tb.sv
// Self-checking testbench for the serial link alarm unit.
`timescale 1ns/10ps
module tb
    import sla_pkg::*;
;
    // ------------------------------------------------------------------
    // Stimulus, observed outputs and bookkeeping
    // ------------------------------------------------------------------
    typedef struct packed {
        sla_evt_t    ev;
        logic [15:0] st;
        logic [15:0] ln;
    } sla_tb_row_t;

    logic        clk;
    logic        reset_n;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        cal_done;
    sla_evt_t    ev;
    sla_evt_t    base;
    logic [15:0] rdata;
    logic        alarm;
    logic        cal_pin;
    logic        link_en;
    logic [11:0] ofs;
    int          bad_count;
    int          compares;
    int          cycles = 0;
    sla_tb_row_t rows [5];

    sla_alarm_unit i_dut (
        .CLK                    (clk),
        .RESET_N                (reset_n),
        .ADDR                   (addr),
        .WDATA                  (wdata),
        .WR                     (wr),
        .RD                     (rd),
        .LANE_FIFO_ERR          (ev.lane_fifo_err),
        .PLL_UNLOCKED           (ev.pll_unlocked),
        .LINK_DATA_PHASE        (ev.link_data_phase),
        .LINK_RESTART           (ev.link_restart),
        .SYSREF_REALIGN         (ev.sysref_realign),
        .DIVIDER_MISMATCH       (ev.divider_mismatch),
        .CAL_DONE               (cal_done),
        .RDATA                  (rdata),
        .ALARM                  (alarm),
        .CALIBRATION_STATUS_PIN (cal_pin),
        .SERIAL_LINK_ENABLE     (link_en),
        .CORE0_OFFSET_ADJUST    (ofs)
    );

    // Clock of 4 ns period.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results;
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One-cycle write strobe; the register updates at the sampling edge.
    task automatic bus_wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just there.
    task automatic bus_rd(input logic [11:0] a, input logic [15:0] exp);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 chk("rdata", rdata, exp);
    endtask

    // Source values held for exactly one cycle, then back to the quiet state.
    task automatic pulse(input sla_evt_t e);
        @(posedge clk) ev <= e;
        @(posedge clk) ev <= base;
    endtask

    task automatic reset_regs;
        bus_rd(SLA_OFF_STATUS, 16'h003F);
        bus_rd(SLA_OFF_MASK, 16'h003F);
        bus_rd(SLA_OFF_LANE, 16'h00FF);
        bus_rd(SLA_OFF_OFFSET, 16'h0000);
        chk("alarm", {15'h0, alarm}, 16'h0000);
    endtask

    // Hang guard: the whole sequence needs well under this many cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        base = '0;
        base.link_data_phase = 1'b1;
        ev = base;
        {addr, wdata, wr, rd, cal_done, bad_count, compares} = '0;
        reset_n = 1'b0;
        // Event order: lanes, pll, data phase, restart, sysref, divider.
        rows[0] = '{ev: {8'h00, 5'b11000}, st: 16'h0012, ln: 16'h0000};
        rows[1] = '{ev: {8'h00, 5'b00000}, st: 16'h000A, ln: 16'h0000};
        rows[2] = '{ev: {8'h00, 5'b01010}, st: 16'h0006, ln: 16'h0000};
        rows[3] = '{ev: {8'h00, 5'b01001}, st: 16'h0003, ln: 16'h0000};
        rows[4] = '{ev: {8'h81, 5'b01000}, st: 16'h0022, ln: 16'h0081};
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        reset_regs();
        // Alarms are only meaningful once the link runs, so clear after enabling.
        bus_wr(SLA_OFF_CTRL, 16'h0001);
        bus_wr(SLA_OFF_STATUS, 16'h003D);
        bus_rd(SLA_OFF_STATUS, 16'h0002);
        chk("link en", {15'h0, link_en}, 16'h0001);
        bus_rd(SLA_OFF_CTRL, 16'h0001);
        bus_rd(SLA_OFF_LANE, 16'h0000);
        // Each source except link restart sets its sticky flag; a zero write keeps it, a one clears.
        foreach (rows[i]) begin
            pulse(rows[i].ev);
            bus_wr(SLA_OFF_STATUS, 16'h0000);
            bus_rd(SLA_OFF_STATUS, rows[i].st);
            bus_rd(SLA_OFF_LANE, rows[i].ln);
            chk("alarm", {15'h0, alarm}, 16'h0000);
            bus_wr(SLA_OFF_STATUS, 16'h003D);
            bus_rd(SLA_OFF_STATUS, 16'h0002);
            bus_rd(SLA_OFF_LANE, 16'h0000);
        end
        // Summary flag, masking and routing to the status pin.
        bus_wr(SLA_OFF_MASK, 16'h0002);
        pulse(rows[2].ev);
        repeat (2) @(posedge clk);
        #1 chk("alarm", {15'h0, alarm}, 16'h0001);
        bus_rd(SLA_OFF_SUMMARY, 16'h0001);
        bus_wr(SLA_OFF_CTRL, 16'h0005);
        repeat (2) @(posedge clk);
        #1 chk("pin", {15'h0, cal_pin}, 16'h0001);
        bus_wr(SLA_OFF_MASK, 16'h0006);
        bus_rd(SLA_OFF_MASK, 16'h0006);
        repeat (3) @(posedge clk);
        #1 chk("alarm", {15'h0, alarm}, 16'h0000);
        chk("pin", {15'h0, cal_pin}, 16'h0000);
        bus_wr(SLA_OFF_CTRL, 16'h0001);
        cal_done <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("pin", {15'h0, cal_pin}, 16'h0001);
        cal_done <= 1'b0;
        bus_wr(SLA_OFF_STATUS, 16'h003D);
        // A lane still in error keeps its bit set through a lane clear written in the same cycle.
        @(posedge clk) ev.lane_fifo_err <= 8'h04;
        bus_wr(SLA_OFF_LANE, 16'h0004);
        bus_rd(SLA_OFF_LANE, 16'h0004);
        @(posedge clk) ev <= base;
        bus_wr(SLA_OFF_LANE, 16'h0004);
        bus_rd(SLA_OFF_LANE, 16'h0000);
        // 64b/66b: start-up and link restart both raise the link flag.
        bus_wr(SLA_OFF_CTRL, 16'h0000);
        bus_wr(SLA_OFF_STATUS, 16'h003D);
        bus_rd(SLA_OFF_STATUS, 16'h0002);
        bus_wr(SLA_OFF_CTRL, 16'h0003);
        bus_rd(SLA_OFF_STATUS, 16'h000A);
        bus_wr(SLA_OFF_STATUS, 16'h003D);
        pulse({8'h00, 5'b01100});
        bus_rd(SLA_OFF_STATUS, 16'h000A);
        // Offset field is 12 bits; the top nibble never sticks.
        bus_wr(SLA_OFF_OFFSET, 16'hFABC);
        bus_rd(SLA_OFF_OFFSET, 16'h0ABC);
        @(posedge clk) #1 chk("rdata idle", rdata, 16'h0000);
        chk("offset", {4'h0, ofs}, 16'h0ABC);
        bus_wr(12'h2C3, 16'h00FF);
        bus_rd(12'h2C3, 16'h0000);
        // A second reset in mid-run brings every status and lane flag back to one.
        @(posedge clk) reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("link en", {15'h0, link_en}, 16'h0000);
        @(posedge clk) reset_n <= 1'b1;
        reset_regs();
        results();
    end
endmodule
